// >>> rtl/vanc_insertion_window_regs.sv
/*
  Vertical ancillary insertion window: AXI4-Lite registers, line/pixel counters,
  and a byte stream mux that swaps video bytes for buffered ancillary bytes.
  Assumes video bytes arrive with start-of-field/start-of-line marks and a field flag,
  all synchronous to aclk, and a sink that honours valid/ready.
*/
// Summary of operation
// RULE1: Each field keeps an 11-bit vertical size at bits 26..16 giving the number of ancillary lines.
// RULE2: Each field keeps an 11-bit horizontal size at bits 10..0 giving the ancillary width per line.
// RULE3: Software should program horizontal sizes and horizontal starts as multiples of eight.
// RULE4: The bottom field keeps an 11-bit vertical start at bits 26..16 and horizontal start at bits 10..0.
// RULE5: Vertical starts count from the line counter, whose first value is one.
// RULE6: Horizontal starts count from the pixel counter, whose first value is zero.
// RULE7: The top field keeps its own start register laid out like the bottom one.
// RULE8: Ancillary bytes replace video while line and pixel lie inside start plus size for the current field.
`timescale 1ns/1ps
module vanc_insertion_window_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [vanc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [vanc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [vanc_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [vanc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [vanc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic vid_valid,
  output logic vid_ready,
  input wire logic [vanc_pkg::BYTE_W-1:0] vid_data,
  input wire logic vid_sof,
  input wire logic vid_sol,
  input wire logic vid_field,
  input wire logic anc_valid,
  output logic anc_ready,
  input wire logic [vanc_pkg::BYTE_W-1:0] anc_data,
  output logic out_valid,
  input wire logic out_ready,
  output vanc_pkg::beat_type out_beat
);
  import vanc_pkg::*;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic in_range(input logic [POS_W-1:0] pos, input logic [POS_W-1:0] start,
                                    input logic [POS_W-1:0] size);
    logic [POS_W:0] end_pos;
    end_pos = {1'b0, start} + {1'b0, size};
    in_range = ({1'b0, pos} >= {1'b0, start}) && ({1'b0, pos} < end_pos);
  endfunction : in_range

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] wd,
                                              input logic [STRB_W-1:0] strb, input logic [DATA_W-1:0] mask);
    logic [DATA_W-1:0] res;
    res = old;
    for (int i = 0; i < STRB_W; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = res & mask;
  endfunction : merge

  // ==========================================================================
  // AXI4-Lite write path
  // ==========================================================================
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt, bvalid_r, bvalid_nxt;
  logic [ADDR_W-1:0] waddr_r, waddr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [STRB_W-1:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic do_write, wr_hit;
  win_reg_type top_start_r, top_start_nxt, top_size_r, top_size_nxt;
  win_reg_type bot_start_r, bot_start_nxt, bot_size_r, bot_size_nxt;
  logic [DATA_W-1:0] ctrl_r, ctrl_nxt;

  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready = !w_held_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  // Write lands once both halves are held and the previous response is gone
  assign do_write = aw_held_r && w_held_r && !bvalid_r;
  assign wr_hit = (waddr_r == ADDR_TOP_START) || (waddr_r == ADDR_TOP_SIZE) || (waddr_r == ADDR_BOT_START) ||
                  (waddr_r == ADDR_BOT_SIZE) || (waddr_r == ADDR_CTRL);

  always_comb begin
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    top_start_nxt = top_start_r;
    top_size_nxt = top_size_r;
    bot_start_nxt = bot_start_r;
    bot_size_nxt = bot_size_r;
    ctrl_nxt = ctrl_r;
    if (s_axi_awvalid && !aw_held_r) begin
      aw_held_nxt = 1'b1;
      waddr_nxt = {s_axi_awaddr[ADDR_W-1:2], 2'b00};
    end
    if (s_axi_wvalid && !w_held_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_write) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit ? RESP_OKAY : RESP_SLVERR;
      unique case (waddr_r)
        ADDR_TOP_START: top_start_nxt = merge(top_start_r, wdata_r, wstrb_r, WIN_WMASK); // RULE7
        ADDR_TOP_SIZE: top_size_nxt = merge(top_size_r, wdata_r, wstrb_r, WIN_WMASK); // RULE1 RULE2
        ADDR_BOT_START: bot_start_nxt = merge(bot_start_r, wdata_r, wstrb_r, WIN_WMASK); // RULE4
        ADDR_BOT_SIZE: bot_size_nxt = merge(bot_size_r, wdata_r, wstrb_r, WIN_WMASK); // RULE1 RULE2
        ADDR_CTRL: ctrl_nxt = merge(ctrl_r, wdata_r, wstrb_r, CTRL_WMASK);
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      top_start_r <= WIN_RESET;
      top_size_r <= WIN_RESET;
      bot_start_r <= WIN_RESET;
      bot_size_r <= WIN_RESET;
      ctrl_r <= CTRL_RESET;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      top_start_r <= top_start_nxt;
      top_size_r <= top_size_nxt;
      bot_start_r <= bot_start_nxt;
      bot_size_r <= bot_size_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  // ==========================================================================
  // Position counters and window decision
  // ==========================================================================
  logic [POS_W-1:0] line_r, line_nxt, pix_r, pix_nxt, cur_line, cur_pix;
  logic field_r, field_nxt, cur_win, accept, fifo_valid;
  logic [BYTE_W-1:0] fifo_data;
  win_reg_type cur_start, cur_size;

  always_comb begin
    cur_line = vid_sof ? LINE_FIRST : line_r; // RULE5
    if (vid_sol && !vid_sof) begin
      cur_line = (line_r == POS_MAX) ? POS_MAX : line_r + 11'h001;
    end
    cur_pix = vid_sol ? PIX_FIRST : pix_r; // RULE6
    cur_start = vid_field ? bot_start_r : top_start_r;
    cur_size = vid_field ? bot_size_r : top_size_r;
    cur_win = ctrl_r[CTRL_EN_BIT] && in_range(cur_line, cur_start.vert, cur_size.vert) &&
              in_range(cur_pix, cur_start.horiz, cur_size.horiz); // RULE8
    line_nxt = line_r;
    pix_nxt = pix_r;
    field_nxt = field_r;
    if (accept) begin
      line_nxt = cur_line;
      pix_nxt = (cur_pix == POS_MAX) ? POS_MAX : cur_pix + 11'h001; // RULE6
      field_nxt = vid_field;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_r <= LINE_FIRST;
      pix_r <= PIX_FIRST;
      field_r <= 1'b0;
    end else begin
      line_r <= line_nxt;
      pix_r <= pix_nxt;
      field_r <= field_nxt;
    end
  end

  // ==========================================================================
  // Ancillary buffer and output stage
  // ==========================================================================
  logic out_valid_r, out_valid_nxt, out_free;
  beat_type out_beat_r, out_beat_nxt;

  // Inside the window the video waits for ancillary bytes rather than send a gap
  assign out_free = !out_valid_r || out_ready;
  assign vid_ready = out_free && (!cur_win || fifo_valid); // RULE8
  assign accept = vid_valid && vid_ready;
  assign out_valid = out_valid_r;
  assign out_beat = out_beat_r;

  vanc_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) vanc_fifo_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(anc_valid),
    .in_ready(anc_ready),
    .in_data(anc_data),
    .out_valid(fifo_valid),
    .out_ready(accept && cur_win),
    .out_data(fifo_data)
  );

  always_comb begin
    out_valid_nxt = out_valid_r;
    out_beat_nxt = out_beat_r;
    if (out_valid_r && out_ready) begin
      out_valid_nxt = 1'b0;
    end
    if (accept) begin
      out_valid_nxt = 1'b1;
      out_beat_nxt.sof = vid_sof;
      out_beat_nxt.sol = vid_sol;
      out_beat_nxt.field = vid_field;
      out_beat_nxt.anc = cur_win;
      out_beat_nxt.data = cur_win ? fifo_data : vid_data; // RULE8
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid_r <= 1'b0;
      out_beat_r <= '0;
    end else begin
      out_valid_r <= out_valid_nxt;
      out_beat_r <= out_beat_nxt;
    end
  end

  // ==========================================================================
  // AXI4-Lite read path
  // ==========================================================================
  logic rvalid_r, rvalid_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [ADDR_W-1:0] raddr;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign raddr = {s_axi_araddr[ADDR_W-1:2], 2'b00};

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      unique case (raddr)
        ADDR_TOP_START: rdata_nxt = top_start_r;
        ADDR_TOP_SIZE: rdata_nxt = top_size_r;
        ADDR_BOT_START: rdata_nxt = bot_start_r;
        ADDR_BOT_SIZE: rdata_nxt = bot_size_r;
        ADDR_CTRL: rdata_nxt = ctrl_r;
        ADDR_STATUS: begin
          rdata_nxt = '0;
          rdata_nxt[STAT_FIELD_BIT] = field_r;
          rdata_nxt[STAT_WIN_BIT] = out_beat_r.anc;
          rdata_nxt[VERT_LSB +: POS_W] = line_r;
          rdata_nxt[HORIZ_LSB +: POS_W] = pix_r;
        end
        default: begin
          rdata_nxt = '0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // ==========================================================================
  // Assertions and covers
  // ==========================================================================
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  size_reserved_zero_a: assert property ((top_size_r & ~WIN_WMASK) == '0 && (bot_size_r & ~WIN_WMASK) == '0) // RULE1
    else $error("size register reserved bits set");
  size_write_lands_a: assert property (do_write && waddr_r == ADDR_BOT_SIZE && wstrb_r == 4'hF
    |=> bot_size_r == ($past(wdata_r) & WIN_WMASK)) // RULE2
    else $error("bottom size write lost");
  bot_start_write_a: assert property (do_write && waddr_r == ADDR_BOT_START && wstrb_r == 4'hF
    |=> bot_start_r == ($past(wdata_r) & WIN_WMASK) && s_axi_bvalid && s_axi_bresp == RESP_OKAY) // RULE4
    else $error("bottom start write lost");
  top_start_write_a: assert property (do_write && waddr_r == ADDR_TOP_START && wstrb_r == 4'hF
    |=> top_start_r == ($past(wdata_r) & WIN_WMASK)) // RULE7
    else $error("top start write lost");
  line_first_a: assert property (accept && vid_sof |=> line_r == LINE_FIRST) // RULE5
    else $error("line counter does not restart at one");
  pix_first_a: assert property (accept && vid_sol |=> pix_r == 11'h001) // RULE6
    else $error("pixel counter does not restart at zero");
  anc_window_a: assert property (accept |=> out_valid && out_beat.anc == $past(cur_win)
    && (!out_beat.anc || out_beat.data == $past(fifo_data))) // RULE8
    else $error("ancillary byte not placed in window");
  win_stall_a: assert property (cur_win && !fifo_valid |-> !vid_ready) // RULE8
    else $error("video taken in window without ancillary byte");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_beat))
    else $error("output beat dropped under back-pressure");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");

  anc_insert_c: cover property (accept && cur_win);
  field_bottom_c: cover property (accept && cur_win && vid_field);
  fifo_full_c: cover property (anc_valid && !anc_ready);
  read_status_c: cover property (s_axi_arvalid && s_axi_arready && raddr == ADDR_STATUS);

endmodule : vanc_insertion_window_regs

// >>> shared/vanc_pkg.sv
/*
  Shared constants and carrier types for the vertical ancillary insertion window block.
  Assumes a single 25 MHz clock domain and AXI4-Lite register access with 32-bit data.
*/
package vanc_pkg;

  // ==========================================================================
  // Clock and bus basics
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 40;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;

  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam logic [ADDR_W-1:0] ADDR_TOP_START = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_TOP_SIZE = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_BOT_START = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_BOT_SIZE = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;

  // ==========================================================================
  // Field layout and reset values
  // ==========================================================================
  localparam int POS_W = 11;
  localparam int VERT_LSB = 16;
  localparam int HORIZ_LSB = 0;
  localparam logic [DATA_W-1:0] WIN_WMASK = 32'h07FF07FF;
  localparam logic [DATA_W-1:0] WIN_RESET = 32'h00000000;
  localparam int CTRL_EN_BIT = 0;
  localparam logic [DATA_W-1:0] CTRL_WMASK = 32'h00000001;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h00000000;
  localparam int STAT_FIELD_BIT = 31;
  localparam int STAT_WIN_BIT = 30;
  localparam logic [POS_W-1:0] LINE_FIRST = 11'h001;
  localparam logic [POS_W-1:0] PIX_FIRST = 11'h000;
  localparam logic [POS_W-1:0] POS_MAX = 11'h7FF;

  // ==========================================================================
  // Bus responses and stream sizes
  // ==========================================================================
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 8;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic [4:0] rsv_hi;
    logic [POS_W-1:0] vert;
    logic [4:0] rsv_lo;
    logic [POS_W-1:0] horiz;
  } win_reg_type;

  typedef struct packed {
    logic sof;
    logic sol;
    logic field;
    logic anc;
    logic [BYTE_W-1:0] data;
  } beat_type;

endpackage : vanc_pkg

// >>> rtl/vanc_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides, width and depth as parameters.
  Assumes one clock and a synchronous active-low reset; depth is a power of two.
*/
`timescale 1ns/1ps
module vanc_fifo #(
  parameter int WIDTH = vanc_pkg::BYTE_W,
  parameter int DEPTH = vanc_pkg::FIFO_DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  import vanc_pkg::*;

  localparam int PW = $clog2(DEPTH);

  // ==========================================================================
  // Storage and pointers
  // ==========================================================================
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic push, pop, full, empty;

  // Extra pointer bit tells full from empty without a counter
  assign full = (wr_ptr_r[PW] != rd_ptr_r[PW]) && (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]);
  assign empty = (wr_ptr_r == rd_ptr_r);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_r[rd_ptr_r[PW-1:0]];
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;

  always_comb begin
    wr_ptr_nxt = wr_ptr_r + (PW+1)'(push);
    rd_ptr_nxt = rd_ptr_r + (PW+1)'(pop);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
    end
  end

  // Storage needs no reset; reads are gated by empty
  always_ff @(posedge aclk) begin
    if (push) begin
      mem_r[wr_ptr_r[PW-1:0]] <= in_data;
    end
  end

endmodule : vanc_fifo

// >>> testbench/vanc_sink_model.sv
/*
  Video sink model for the output byte stream: takes beats, refusing one cycle in four.
  Assumes the block's out_valid/out_ready handshake on aclk and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module vanc_sink_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic stall_en,
  output logic out_ready
);
  import vanc_pkg::*;
  logic [1:0] phase_r;
  logic [1:0] phase_nxt;
  // ==========================================================================
  // Stall pattern
  // ==========================================================================
  // A periodic refusal makes the output stage hold a beat; free-running so it never deadlocks
  always_comb begin
    phase_nxt = phase_r + 2'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_nxt;
    end
  end
  assign out_ready = !(stall_en && phase_r == 2'h3);
endmodule : vanc_sink_model

// >>> testbench/vanc_insertion_window_regs_test.sv
/*
  Self-checking bench: AXI4-Lite register tasks, ancillary FIFO fill, video fields with expected beats.
  Assumes the design package, the block and the sink model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin err_total++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); end end
module vanc_insertion_window_regs_test;
  import vanc_pkg::*;
  logic aclk, aresetn, stall_en, out_valid, out_ready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, d;
  logic [STRB_W-1:0] s_axi_wstrb, wr_strb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic vid_valid, vid_ready, vid_sof, vid_sol, vid_field, anc_valid, anc_ready, en;
  logic [BYTE_W-1:0] vid_data, anc_data;
  beat_type out_beat, e;
  beat_type exp_q[$];
  logic [BYTE_W-1:0] anc_q[$];
  logic [POS_W-1:0] win_v[2], win_h[2], size_v[2], size_h[2];
  logic [ADDR_W-1:0] win_addr[4] = '{ADDR_TOP_START, ADDR_TOP_SIZE, ADDR_BOT_START, ADDR_BOT_SIZE};
  int err_total, tests_run, anc_seq;

  vanc_insertion_window_regs vanc_insertion_window_regs_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .vid_valid(vid_valid),
    .vid_ready(vid_ready), .vid_data(vid_data), .vid_sof(vid_sof), .vid_sol(vid_sol),
    .vid_field(vid_field), .anc_valid(anc_valid), .anc_ready(anc_ready), .anc_data(anc_data),
    .out_valid(out_valid), .out_ready(out_ready), .out_beat(out_beat));
  vanc_sink_model vanc_sink_model_inst (.aclk(aclk), .aresetn(aresetn), .stall_en(stall_en),
    .out_ready(out_ready));

  initial begin
    aclk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) aclk = ~aclk;
  end

  // ==========================================================================
  // Closing and waits
  // ==========================================================================
  task automatic wrap_up();
    if (err_total == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic fail_wait(input string what);
    err_total++;
    $display("MISMATCH %s expected handshake seen none", what);
    wrap_up();
  endtask : fail_wait

  // ==========================================================================
  // AXI4-Lite master; ready is looked at on the falling edge, so it equals what the rising edge samples
  // ==========================================================================
  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd, output logic [1:0] resp);
    logic a_t, w_t, done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= wd;
    s_axi_wstrb <= wr_strb;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(negedge aclk);
      a_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (a_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (done) s_axi_bready <= 1'b0;
    end
    if (!done) fail_wait("write");
  endtask : axi_write

  task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] rd, output logic [1:0] resp);
    logic a_t, done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(negedge aclk);
      a_t = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (a_t) s_axi_arvalid <= 1'b0;
      if (done) s_axi_rready <= 1'b0;
    end
    if (!done) fail_wait("read");
  endtask : axi_read

  // ==========================================================================
  // Window setup, FIFO fill, video fields
  // ==========================================================================
  task automatic setwin(input logic fld, input logic [POS_W-1:0] vs, hs, vz, hz);
    logic [1:0] rs;
    win_v[fld] = vs;
    win_h[fld] = hs;
    size_v[fld] = vz;
    size_h[fld] = hz;
    axi_write(fld ? ADDR_BOT_START : ADDR_TOP_START, {5'h00, vs, 5'h00, hs}, rs);
    `CHK("start write resp", RESP_OKAY, rs)
    axi_write(fld ? ADDR_BOT_SIZE : ADDR_TOP_SIZE, {5'h00, vz, 5'h00, hz}, rs);
    `CHK("size write resp", RESP_OKAY, rs)
  endtask : setwin

  task automatic fill_fifo();
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      logic taken;
      taken = 1'b0;
      anc_data <= 8'(8'hA0 + anc_seq);
      anc_valid <= 1'b1;
      for (int n = 0; n < 50 && !taken; n++) begin
        @(negedge aclk);
        taken = anc_ready;
        @(posedge aclk);
      end
      if (!taken) fail_wait("anc push");
      anc_q.push_back(8'(8'hA0 + anc_seq));
      anc_seq++;
    end
    anc_valid <= 1'b0;
    @(negedge aclk);
    `CHK("anc_ready when full", 1'b0, anc_ready)
  endtask : fill_fifo

  task automatic send_field(input logic fld, input int nlines, input int npix);
    beat_type b;
    logic taken;
    for (int l = 1; l <= nlines; l++) begin
      for (int p = 0; p < npix; p++) begin
        b.sof = (l == 1 && p == 0);
        b.sol = (p == 0);
        b.field = fld;
        b.anc = en && l >= win_v[fld] && l < win_v[fld] + size_v[fld] &&
                p >= win_h[fld] && p < win_h[fld] + size_h[fld];
        b.data = b.anc ? anc_q.pop_front() : 8'(l * 16 + p);
        exp_q.push_back(b);
        vid_data <= 8'(l * 16 + p);
        vid_sof <= b.sof;
        vid_sol <= b.sol;
        vid_field <= fld;
        vid_valid <= 1'b1;
        taken = 1'b0;
        for (int n = 0; n < 50 && !taken; n++) begin
          @(negedge aclk);
          taken = vid_ready;
          @(posedge aclk);
        end
        if (!taken) fail_wait("video");
      end
    end
    vid_valid <= 1'b0;
    for (int n = 0; n < 200 && exp_q.size() != 0; n++) @(posedge aclk);
    if (exp_q.size() != 0) fail_wait("drain");
  endtask : send_field

  // Every beat the sink takes is compared with the next expected one
  always @(negedge aclk) begin
    if (aresetn && out_valid && out_ready) begin
      if (exp_q.size() == 0) begin
        `CHK("unexpected beat", 1'b0, 1'b1)
      end else begin
        e = exp_q.pop_front();
        `CHK("out_beat", e, out_beat)
      end
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {aresetn, stall_en, en, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {vid_valid, vid_sof, vid_sol, vid_field, anc_valid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, vid_data, anc_data} = '0;
    err_total = 0;
    tests_run = 0;
    anc_seq = 0;
    wr_strb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (win_addr[i]) begin
      axi_read(win_addr[i], d, r);
      `CHK("reset value", WIN_RESET, d)
    end
    // All ones: only the two 11-bit fields keep bits, reserved bits read zero
    foreach (win_addr[i]) begin
      axi_write(win_addr[i], 32'hFFFFFFFF, r);
      axi_read(win_addr[i], d, r);
      `CHK("field mask", WIN_WMASK, d)
    end
    axi_read(8'h20, d, r);
    `CHK("unmapped read resp", RESP_SLVERR, r)
    axi_write(ADDR_STATUS, 32'h00000001, r);
    `CHK("status write resp", RESP_SLVERR, r)
    // Only byte lane 0 written: the low byte of the horizontal size clears, the rest stays
    wr_strb = 4'h1;
    axi_write(ADDR_BOT_SIZE, 32'h00000000, r);
    wr_strb = 4'hF;
    axi_read(ADDR_BOT_SIZE, d, r);
    `CHK("byte lane write", 32'h07FF0700, d)
    // Top window on line 2, pixels 8 to 15; horizontal start and size are multiples of eight
    setwin(1'b0, 11'h002, 11'h008, 11'h001, 11'h008);
    axi_write(ADDR_CTRL, 32'h00000001, r);
    en = 1'b1;
    stall_en <= 1'b1;
    fill_fifo();
    @(posedge aclk);
    send_field(1'b0, 3, 24);
    @(negedge aclk);
    `CHK("anc_ready when empty", 1'b1, anc_ready)
    // Bottom window at the first line and first pixel; top window must not apply to this field
    setwin(1'b1, 11'h001, 11'h000, 11'h001, 11'h008);
    fill_fifo();
    @(posedge aclk);
    send_field(1'b1, 2, 16);
    // Last byte was bottom field, line 2, pixel 15 outside the window: next pixel 16
    axi_read(ADDR_STATUS, d, r);
    `CHK("status", 32'h80020010, d)
    // Disabled: the FIFO is empty, so a wrong insertion would stall the stream
    axi_write(ADDR_CTRL, 32'h00000000, r);
    en = 1'b0;
    send_field(1'b0, 3, 24);
    wrap_up();
  end
endmodule : vanc_insertion_window_regs_test
